// ### design/ezat_consts.vh
// constants for the external zone access timing block
// assumes inclusion by the zone timing sequencer
`ifndef EZAT_CONSTS_VH
`define EZAT_CONSTS_VH
// register byte offsets (apb, one word each)
`define EZAT_OFF_ZONE_CFG0 12'h000
`define EZAT_OFF_CTRL 12'h020
`define EZAT_OFF_STATUS 12'h024
`define EZAT_OFF_LAST_WS 12'h028
`define EZAT_ZONE_STRIDE 12'h004
// zone_timing_config field positions
`define EZAT_RD_LEAD_LSB 0
`define EZAT_RD_ACT_LSB 2
`define EZAT_RD_TRAIL_LSB 5
`define EZAT_WR_LEAD_LSB 7
`define EZAT_WR_ACT_LSB 9
`define EZAT_WR_TRAIL_LSB 12
`define EZAT_READY_EN_BIT 14
`define EZAT_READY_ASYNC_BIT 15
`define EZAT_DOUBLE_BIT 16
`define EZAT_CFG_WIDTH 17
`define EZAT_CFG_RESET 17'h1FFFF
// control fields
`define EZAT_CTRL_DIV_BIT 0
// phase encodings
`define EZAT_PH_IDLE 2'h0
`define EZAT_PH_LEAD 2'h1
`define EZAT_PH_ACTIVE 2'h2
`define EZAT_PH_TRAIL 2'h3
`endif

// ### design/ezat_phase_counter.v
// down counter that times one access phase in timing-clock ticks
// assumes tick is a one-cycle pulse on pclk marking each timing-clock edge
`timescale 1ns/100ps
`default_nettype none
module ezat_phase_counter #(
  parameter W = 5
) (
  input wire pclk,
  input wire presetn,
  input wire load,
  input wire [W-1:0] load_val,
  input wire tick,
  input wire hold,
  output wire done
);
  reg [W-1:0] cnt_ff;
  reg [W-1:0] nxt_cnt;

  // load wins; holding freezes the count while ready says wait
  always @* begin
    nxt_cnt = cnt_ff;
    if (load) begin
      nxt_cnt = load_val;
    end else if (tick && !hold && cnt_ff != {W{1'b0}}) begin
      nxt_cnt = cnt_ff - {{(W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= {W{1'b0}};
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // flags the last period even while held; the caller gates its advance
  // with hold, which keeps load and hold free of a loop through done
  assign done = tick && (cnt_ff <= {{(W-1){1'b0}}, 1'b1});
endmodule
`default_nettype wire

// ### design/ezat_zone_sequencer.v
// zone access sequencer: lead, active and trail phases per zone timing config
// assumes an apb master for configuration and a simple request port from the core
`timescale 1ns/100ps
`default_nettype none
`include "ezat_consts.vh"
module ezat_zone_sequencer #(
  parameter ZONES = 8,
  parameter ZW = 3
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire acc_req,
  input wire acc_write,
  input wire [ZW-1:0] acc_zone,
  output wire acc_busy,
  output reg acc_done_ff,
  input wire external_ready_input,
  output reg zone_select_n_ff,
  output reg read_strobe_n_ff,
  output reg write_strobe_n_ff,
  output reg [ZW-1:0] zone_id_ff
);
  reg [`EZAT_CFG_WIDTH-1:0] cfg_ff [0:ZONES-1];
  reg div_ff;
  reg tick_ff;
  reg rdy_meta_ff;
  reg rdy_sync_ff;
  reg rdy_async_ff;
  reg [1:0] phase_ff;
  reg wr_ff;
  reg pend_ff;
  reg pend_wr_ff;
  reg [ZW-1:0] pend_zone_ff;
  reg [7:0] ws_ff;
  reg [7:0] last_ws_ff;
  reg [1:0] nxt_phase;
  reg [4:0] ld_val;
  reg ld;
  wire cnt_last;
  wire ph_end;
  wire [`EZAT_CFG_WIDTH-1:0] cur_cfg;
  wire use_rdy;
  wire rdy_now;
  wire wr_en;
  wire in_cfg;
  wire [ZW-1:0] cfg_idx;
  integer i;

  // apb slave: zero wait, errors on unmapped offsets
  assign pready = 1'b1;
  assign in_cfg = (paddr < (`EZAT_ZONE_STRIDE * ZONES)) && (paddr[1:0] == 2'b00);
  assign cfg_idx = paddr[ZW+1:2];
  assign pslverr = psel && penable && !(in_cfg || paddr == `EZAT_OFF_CTRL ||
                   paddr == `EZAT_OFF_STATUS || paddr == `EZAT_OFF_LAST_WS);
  assign wr_en = psel && penable && pwrite && !pslverr;

  // config storage, one word per zone; values stored as written
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < ZONES; i = i + 1) begin
        cfg_ff[i] <= `EZAT_CFG_RESET;
      end
      div_ff <= 1'b0;
    end else if (wr_en) begin
      if (in_cfg) begin
        cfg_ff[cfg_idx] <= pwdata[`EZAT_CFG_WIDTH-1:0];
      end else if (paddr == `EZAT_OFF_CTRL) begin
        div_ff <= pwdata[`EZAT_CTRL_DIV_BIT];
      end
    end
  end

  // read mux; reserved bits read zero
  always @* begin
    prdata = 32'h00000000;
    if (in_cfg) begin
      prdata[`EZAT_CFG_WIDTH-1:0] = cfg_ff[cfg_idx];
    end else if (paddr == `EZAT_OFF_CTRL) begin
      prdata[0] = div_ff;
    end else if (paddr == `EZAT_OFF_STATUS) begin
      prdata[1:0] = phase_ff;
      prdata[2] = pend_ff;
      prdata[3] = rdy_sync_ff;
    end else if (paddr == `EZAT_OFF_LAST_WS) begin
      prdata[7:0] = last_ws_ff;
    end
  end

  // timing-clock tick: every pclk, or every other pclk when divided
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= div_ff ? !tick_ff : 1'b1;
    end
  end

  // ready pin passes two flops; async mode adds one more stage
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_meta_ff <= 1'b0;
      rdy_sync_ff <= 1'b0;
      rdy_async_ff <= 1'b0;
    end else begin
      rdy_meta_ff <= external_ready_input;
      rdy_sync_ff <= rdy_meta_ff;
      rdy_async_ff <= rdy_sync_ff;
    end
  end

  assign cur_cfg = cfg_ff[zone_id_ff];
  assign use_rdy = cur_cfg[`EZAT_READY_EN_BIT];
  assign rdy_now = cur_cfg[`EZAT_READY_ASYNC_BIT] ? rdy_async_ff : rdy_sync_ff;

  wire act_last;
  wire stall;
  // stall only in the active phase's last period so the +1 period still counts
  assign act_last = tick_ff && (phase_ff == `EZAT_PH_ACTIVE) && cnt_last;
  // no ready sampling means no stall, so wait states stay zero
  assign stall = act_last && use_rdy && !rdy_now;
  // a phase ends on its last period unless ready holds it open
  assign ph_end = cnt_last && !stall;

  ezat_phase_counter #(.W(5)) u_cnt (
    .pclk(pclk),
    .presetn(presetn),
    .load(ld),
    .load_val(ld_val),
    .tick(tick_ff),
    .hold(stall),
    .done(cnt_last)
  );

  assign acc_busy = pend_ff || (phase_ff != `EZAT_PH_IDLE);

  // phase length for the next phase, doubled when selected
  function [4:0] plen;
    input [`EZAT_CFG_WIDTH-1:0] c;
    input w;
    input [1:0] ph;
    reg [2:0] v;
    begin
      v = 3'h0;
      case (ph)
        `EZAT_PH_LEAD: v = w ? {1'b0, c[`EZAT_WR_LEAD_LSB +: 2]} : {1'b0, c[`EZAT_RD_LEAD_LSB +: 2]};
        `EZAT_PH_ACTIVE: v = w ? c[`EZAT_WR_ACT_LSB +: 3] : c[`EZAT_RD_ACT_LSB +: 3];
        `EZAT_PH_TRAIL: v = w ? {1'b0, c[`EZAT_WR_TRAIL_LSB +: 2]} : {1'b0, c[`EZAT_RD_TRAIL_LSB +: 2]};
        default: v = 3'h0;
      endcase
      plen = c[`EZAT_DOUBLE_BIT] ? {1'b0, v, 1'b0} : {2'b00, v};
      if (ph == `EZAT_PH_ACTIVE) begin
        plen = plen + 5'h01; // active always carries one extra period
      end
    end
  endfunction

  // next phase; a zero-length lead or trail is skipped
  always @* begin
    nxt_phase = phase_ff;
    ld = 1'b0;
    ld_val = 5'h00;
    case (phase_ff)
      `EZAT_PH_IDLE: begin
        if (pend_ff && tick_ff) begin
          ld = 1'b1;
          ld_val = plen(cfg_ff[pend_zone_ff], pend_wr_ff, `EZAT_PH_LEAD);
          nxt_phase = `EZAT_PH_LEAD;
          if (ld_val == 5'h00) begin
            ld_val = plen(cfg_ff[pend_zone_ff], pend_wr_ff, `EZAT_PH_ACTIVE);
            nxt_phase = `EZAT_PH_ACTIVE;
          end
        end
      end
      `EZAT_PH_LEAD: begin
        if (ph_end) begin
          ld = 1'b1;
          ld_val = plen(cur_cfg, wr_ff, `EZAT_PH_ACTIVE);
          nxt_phase = `EZAT_PH_ACTIVE;
        end
      end
      `EZAT_PH_ACTIVE: begin
        if (ph_end) begin
          ld = 1'b1;
          ld_val = plen(cur_cfg, wr_ff, `EZAT_PH_TRAIL);
          nxt_phase = (ld_val == 5'h00) ? `EZAT_PH_IDLE : `EZAT_PH_TRAIL;
        end
      end
      `EZAT_PH_TRAIL: begin
        if (ph_end) begin
          nxt_phase = `EZAT_PH_IDLE;
        end
      end
      default: nxt_phase = `EZAT_PH_IDLE;
    endcase
  end

  // phase and strobes move on tick edges only; request capture and the done clear run every pclk
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_ff <= `EZAT_PH_IDLE;
      wr_ff <= 1'b0;
      pend_ff <= 1'b0;
      pend_wr_ff <= 1'b0;
      pend_zone_ff <= {ZW{1'b0}};
      zone_id_ff <= {ZW{1'b0}};
      ws_ff <= 8'h00;
      last_ws_ff <= 8'h00;
      acc_done_ff <= 1'b0;
      zone_select_n_ff <= 1'b1;
      read_strobe_n_ff <= 1'b1;
      write_strobe_n_ff <= 1'b1;
    end else begin
      acc_done_ff <= 1'b0;
      if (acc_req && !acc_busy) begin
        pend_ff <= 1'b1;
        pend_wr_ff <= acc_write;
        pend_zone_ff <= acc_zone;
      end
      phase_ff <= nxt_phase;
      if (stall) begin
        ws_ff <= ws_ff + 8'h01; // one extra period per not-ready sample
      end
      if (phase_ff == `EZAT_PH_IDLE && nxt_phase != `EZAT_PH_IDLE) begin
        pend_ff <= 1'b0;
        wr_ff <= pend_wr_ff;
        zone_id_ff <= pend_zone_ff; // this zone's config is used throughout
        ws_ff <= 8'h00;
        zone_select_n_ff <= 1'b0;
      end
      if (nxt_phase == `EZAT_PH_ACTIVE && phase_ff != `EZAT_PH_ACTIVE) begin
        read_strobe_n_ff <= (phase_ff == `EZAT_PH_IDLE) ? pend_wr_ff : wr_ff;
        write_strobe_n_ff <= (phase_ff == `EZAT_PH_IDLE) ? !pend_wr_ff : !wr_ff;
      end
      if (phase_ff == `EZAT_PH_ACTIVE && nxt_phase != `EZAT_PH_ACTIVE) begin
        read_strobe_n_ff <= 1'b1;
        write_strobe_n_ff <= 1'b1;
      end
      if (phase_ff != `EZAT_PH_IDLE && nxt_phase == `EZAT_PH_IDLE) begin
        zone_select_n_ff <= 1'b1;
        acc_done_ff <= 1'b1;
        last_ws_ff <= ws_ff;
      end
    end
  end
endmodule
`default_nettype wire

// ### testbench/ezat_zone_monitor.sv
// checker: strobe nesting, done pulse, zone hold
// assumes binding onto the zone sequencer top
`timescale 1ns/100ps
`default_nettype none
module ezat_zone_monitor #(
  parameter ZW = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic acc_busy,
  input wire logic acc_done_ff,
  input wire logic zone_select_n_ff,
  input wire logic read_strobe_n_ff,
  input wire logic write_strobe_n_ff,
  input wire logic [ZW-1:0] zone_id_ff
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // zone select edges open and close an access
  sequence s_open;
    $fell(zone_select_n_ff);
  endsequence
  sequence s_close;
    $rose(zone_select_n_ff);
  endsequence
  // bench never runs an access on a zone with a zero lead
  AST_LEAD_FIRST: assert property (s_open |-> read_strobe_n_ff && write_strobe_n_ff)
    else $error("strobe with zone select");
  AST_NEST: assert property (!read_strobe_n_ff || !write_strobe_n_ff |-> !zone_select_n_ff)
    else $error("strobe outside zone");
  AST_ONE_DIR: assert property (1'b1 |-> read_strobe_n_ff || write_strobe_n_ff)
    else $error("both strobes low");
  AST_CLOSE_DONE: assert property (s_close |-> ##[0:1] acc_done_ff)
    else $error("no done after access");
  AST_DONE_IDLE: assert property (acc_done_ff |-> zone_select_n_ff && read_strobe_n_ff)
    else $error("done while active");
  AST_DONE_PULSE: assert property (acc_done_ff |=> !acc_done_ff)
    else $error("done too long");
  AST_BUSY: assert property (!zone_select_n_ff |-> acc_busy)
    else $error("idle in access");
  AST_ZONE_HOLD: assert property (!zone_select_n_ff && !$past(zone_select_n_ff) |-> $stable(zone_id_ff))
    else $error("zone changed");
endmodule
`default_nettype wire

// ### testbench/ezat_ext_dev.sv
// external device model: ready low for stall cycles per strobe
// assumes active-low strobes; ready has a pull-up
`timescale 1ns/100ps
`default_nettype none
module ezat_ext_dev (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [3:0] stall,
  output logic ready
);
  logic [3:0] cnt_ff;
  // counts strobe cycles, saturating at stall
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_ff <= 4'h0;
    else if (rd_n && wr_n) cnt_ff <= 4'h0;
    else if (cnt_ff < stall) cnt_ff <= cnt_ff + 4'h1;
  end
  // pulled high outside strobes, slow answer inside
  assign ready = (rd_n && wr_n) || (cnt_ff >= stall);
endmodule
`default_nettype wire

// ### testbench/testbench.sv
// bench: apb setup, timed accesses, ready stalls
// assumes the sequencer, its checker and the device model
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam ZW = 3;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic acc_req = 1'b0, acc_write = 1'b0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  logic [2:0] acc_zone = 3'h0;
  logic [3:0] stall = 4'h0;
  wire [31:0] prdata;
  wire [2:0] zid;
  wire pready, pslverr, busy, done, rdy, zs_n, rd_n, wr_n;
  integer n_fail = 0, checks_done = 0, ma, m;
  always #25 pclk = ~pclk;
  ezat_zone_sequencer #(.ZW(ZW)) i_ezat_zone_sequencer (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .acc_req(acc_req), .acc_write(acc_write), .acc_zone(acc_zone),
    .acc_busy(busy), .acc_done_ff(done), .external_ready_input(rdy), .zone_select_n_ff(zs_n),
    .read_strobe_n_ff(rd_n), .write_strobe_n_ff(wr_n), .zone_id_ff(zid));
  ezat_ext_dev i_ezat_ext_dev (.pclk(pclk), .presetn(presetn), .rd_n(rd_n), .wr_n(wr_n),
    .stall(stall), .ready(rdy));
  task results;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer; bounded wait on pready
  task apb(input w, input [11:0] a, input [31:0] d);
    integer k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k = k + 1;
    end while (!pready && k < 20);
    if (k == 20) begin
      n_fail = n_fail + 1;
      $display("[ERR] %0t apb wait %h limit %h", $time, k, 20);
      results;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one access; phase lengths counted in pclk cycles, ea 0 skips active
  task run(input [2:0] z, input w, input [31:0] el, input [31:0] ea, input [31:0] et);
    integer l, t, k;
    l = 0;
    ma = 0;
    t = 0;
    @(posedge pclk);
    acc_req <= 1'b1;
    acc_write <= w;
    acc_zone <= z;
    @(posedge pclk);
    acc_req <= 1'b0;
    for (k = 0; k < 99 && !done; k = k + 1) begin
      @(negedge pclk);
      if (!zs_n && !(w ? wr_n : rd_n)) ma = ma + 1;
      else if (!zs_n && ma == 0) l = l + 1;
      else if (!zs_n) t = t + 1;
    end
    if (k == 99) begin
      n_fail = n_fail + 1;
      $display("[ERR] %0t access wait %h limit %h", $time, k, 99);
      results;
    end
    chk(l, el);
    chk(t, et);
    chk(zid, z);
    if (ea != 0) chk(ma, ea);
  endtask
  task t_regs;
    apb(1'b1, 12'h020, 32'h0);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0001FFFF);
    apb(1'b0, 12'h024, 32'h0);
    chk(rd, 32'h00000008);
    apb(1'b1, 12'h010, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h030, 32'h0);
    chk(err, 32'h1);
    $display("t_regs done");
  endtask
  task t_phases;
    apb(1'b1, 12'h008, 32'h00000721);
    apb(1'b1, 12'h014, 32'h000111E9);
    run(3'h2, 1'b0, 1, 1, 1);
    run(3'h2, 1'b1, 2, 4, 0);
    run(3'h5, 1'b0, 2, 5, 6);
    run(3'h5, 1'b1, 6, 1, 2);
    $display("t_phases done");
  endtask
  // device stalls six cycles; ignored, then sync, then async
  task t_ready;
    stall <= 4'h6;
    apb(1'b1, 12'h004, 32'h0000068D);
    run(3'h1, 1'b0, 1, 4, 0);
    apb(1'b0, 12'h028, 32'h0);
    chk(rd, 32'h0);
    for (m = 0; m < 2; m = m + 1) begin
      apb(1'b1, 12'h004, m ? 32'h0000C68D : 32'h0000468D);
      run(3'h1, m[0], 1, 0, 0);
      apb(1'b0, 12'h028, 32'h0);
      // ready low six cycles from strobe; sync copy lags two (async three), last period opens after three
      chk(rd, 32'd5 + m);
      chk(ma, 32'd9 + m);
    end
    $display("t_ready done");
  endtask
  // halved tick doubles every phase in pclk cycles
  task t_div;
    apb(1'b1, 12'h020, 32'h1);
    run(3'h2, 1'b0, 2, 2, 2);
    $display("t_div done");
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_phases;
    t_ready;
    t_div;
    results;
  end
endmodule
bind ezat_zone_sequencer ezat_zone_monitor #(.ZW(ZW)) i_ezat_zone_monitor (.pclk(pclk), .presetn(presetn),
  .acc_busy(acc_busy), .acc_done_ff(acc_done_ff), .zone_select_n_ff(zone_select_n_ff),
  .read_strobe_n_ff(read_strobe_n_ff), .write_strobe_n_ff(write_strobe_n_ff), .zone_id_ff(zone_id_ff));
`default_nettype wire
